// *** rtl/scsr_defs.vh ***
/*
  constants of the serial channel string reader: register offsets, field
  positions, reset values, result codes and timing counts.
  assumes it is included by its bare name from rtl/ and holds definitions only.
*/
`ifndef SCSR_DEFS_VH
`define SCSR_DEFS_VH

// register byte offsets
`define SCSR_REG_CHAN 8'h00
`define SCSR_REG_TERM 8'h04
`define SCSR_REG_TMO 8'h08
`define SCSR_REG_READ 8'h0C
`define SCSR_REG_CANCEL 8'h10
`define SCSR_REG_RCVAR 8'h14
`define SCSR_REG_STATUS 8'h18
`define SCSR_REG_TMO_IND 8'h1C

// field positions
`define SCSR_CHAN_OPEN_BIT 0
`define SCSR_CHAN_CLOSE_BIT 1
`define SCSR_CHAN_NUM_LSB 4
`define SCSR_READ_GLOBAL_BIT 15

// reset values and timeout ceiling
`define SCSR_RST_TERM 8'h00
`define SCSR_RST_TMO 14'h0000
`define SCSR_RST_RCVAR 8'h63
`define SCSR_TMO_MAX 14'h26AC

// result codes
`define SCSR_RC_OK 5'h00
`define SCSR_RC_TIMEOUT 5'h01
`define SCSR_RC_CANCEL 5'h02
`define SCSR_RC_OC_OVERRUN 5'h03
`define SCSR_RC_OC_FRAME 5'h04
`define SCSR_RC_ABORT 5'h05
`define SCSR_RC_TASK_END 5'h06
`define SCSR_RC_OC_OTHER 5'h07
`define SCSR_RC_EX_OVERRUN 5'h08
`define SCSR_RC_EX_PARITY 5'h09
`define SCSR_RC_EX_FRAME 5'h0A
`define SCSR_RC_EX_OVERFLOW 5'h0B
`define SCSR_RC_EX_OTHER 5'h0C
`define SCSR_RC_EX_TMPQ 5'h15
`define SCSR_RC_EX_SLVQ 5'h16

// timing: tick period in ms, clock rate in kHz, tick in cycles
`define SCSR_TICK_MS 10
`define SCSR_CLK_KHZ 50000
`define SCSR_TICK_CYC (`SCSR_TICK_MS * `SCSR_CLK_KHZ)

`endif

// *** rtl/scsr_tick.v ***
/*
  free running divider giving a one-cycle pulse every tick period.
  assumes an active-low reset whose release is already synchronised.
*/
`timescale 1ns/1ns
`default_nettype none
module scsr_tick #(
  parameter CNT_W = 20,
  parameter TICK_CYCLES = 500000
) (
  input wire clk,
  input wire rst_n,
  output reg tick
);
  localparam [31:0] LAST_FULL = TICK_CYCLES - 1; // end of the period, full width
  localparam [CNT_W-1:0] LAST = LAST_FULL[CNT_W-1:0]; // CNT_W is chosen wide enough
  reg [CNT_W-1:0] cnt; // cycles inside the current period

  // wrap at the end of the period and pulse once
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= {CNT_W{1'b0}};
      tick <= 1'b0;
    end else if (cnt == LAST) begin
      cnt <= {CNT_W{1'b0}};
      tick <= 1'b1;
    end else begin
      cnt <= cnt + {{(CNT_W-1){1'b0}}, 1'b1};
      tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// *** rtl/scsr_errcode.v ***
/*
  maps the receive fault lines of the selected serial port to one result code.
  assumes fault lines are single-cycle flags from logic on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none
`include "scsr_defs.vh"
module scsr_errcode (
  input wire exp_port,
  input wire [2:0] err_onchip,
  input wire [6:0] err_exp,
  output reg hit,
  output reg [4:0] code
);
  // lowest code wins when several faults arrive together
  always @* begin
    hit = 1'b1;
    code = `SCSR_RC_OK;
    if (!exp_port) begin
      if (err_onchip[0]) code = `SCSR_RC_OC_OVERRUN;
      else if (err_onchip[1]) code = `SCSR_RC_OC_FRAME;
      else if (err_onchip[2]) code = `SCSR_RC_OC_OTHER;
      else hit = 1'b0;
    end else begin
      if (err_exp[0]) code = `SCSR_RC_EX_OVERRUN;
      else if (err_exp[1]) code = `SCSR_RC_EX_PARITY;
      else if (err_exp[2]) code = `SCSR_RC_EX_FRAME;
      else if (err_exp[3]) code = `SCSR_RC_EX_OVERFLOW;
      else if (err_exp[4]) code = `SCSR_RC_EX_OTHER;
      else if (err_exp[5]) code = `SCSR_RC_EX_TMPQ;
      else if (err_exp[6]) code = `SCSR_RC_EX_SLVQ;
      else hit = 1'b0;
    end
  end
endmodule
`default_nettype wire

// *** rtl/scsr_top.v ***
/*
  serial channel string reader: channel open/close, terminated string read
  into a column, read timeout, result code written back to a variable.
  assumes the serial port delivers bytes and fault flags on SYS_CLK, and that
  the variable store outside answers reads one cycle after the strobe.
*/
`timescale 1ns/1ns
`default_nettype none
`include "scsr_defs.vh"
module scsr_top #(
  parameter [3:0] OWN_CHAN = 4'h0,
  parameter EXP_PORT = 0,
  parameter TICK_CYCLES = `SCSR_TICK_CYC
) (
  input wire SYS_CLK,
  input wire RSTN,
  // register port
  // writes act on the edge that sees the strobe
  input wire [7:0] BUS_ADDR,
  input wire [15:0] BUS_WDATA,
  input wire BUS_WR,
  input wire BUS_RD,
  output reg [15:0] BUS_RDATA,
  // serial receive side
  input wire RX_VALID,
  input wire [7:0] RX_DATA,
  input wire [2:0] RX_ERR_ONCHIP,
  input wire [6:0] RX_ERR_EXP,
  // program engine events
  input wire PROG_ABORT,
  input wire TASK_END,
  // variable store
  // the store answers a read strobe with data in the following cycle
  output reg VAR_RD,
  output reg VAR_WR,
  output reg [7:0] VAR_ADDR,
  output reg [15:0] VAR_WDATA,
  input wire [15:0] VAR_RDATA,
  // column store
  output reg COL_WR,
  output reg COL_GLOBAL,
  output reg [9:0] COL_ADDR,
  output reg [7:0] COL_DATA,
  // status
  output reg CHAN_OPEN,
  output reg RX_ENABLE,
  output reg READ_BUSY,
  output reg READ_DONE,
  output reg [4:0] RESULT_CODE
);

  ////////////////////////////////////////////////////////////////////////////
  // states
  // the indirect timeout takes two states: the store answers a cycle after
  // its strobe, so the value can only be taken on the edge after that
  localparam [2:0] ST_IDLE = 3'h0; // waiting for a command
  localparam [2:0] ST_READ = 3'h1; // collecting bytes
  localparam [2:0] ST_REPORT = 3'h2; // writing the result code
  localparam [2:0] ST_FETCH = 3'h3; // store reads the timeout variable
  localparam [2:0] ST_LOAD = 3'h4; // timeout register takes the answer

  ////////////////////////////////////////////////////////////////////////////
  // reset release
  reg rst_meta; // first stage of reset release
  reg rst_n; // released reset used everywhere else

  // assert at once, release two edges later
  // every flop leaves reset on the same edge, so no half-released state
  // can be seen; the raw pin is read by these two flops only
  always @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register state
  // software settings first, then the state of the read in progress
  reg [7:0] term; // terminator byte
  reg [13:0] tmo; // read timeout in hundredths of a second
  reg [7:0] rc_var; // variable that receives the result code
  reg [2:0] state; // sequencer state
  // the running count is a copy, so a timeout written during a read only
  // applies to the next read
  reg [13:0] tmo_cnt; // remaining ticks of the running read, zero is endless
  reg [9:0] col_ptr; // next column to fill
  reg [4:0] code; // result of the current read

  ////////////////////////////////////////////////////////////////////////////
  // command decode
  // each command is one bus write; the offset names the command, and on the channel register the data bits pick open or close
  wire wr_chan = BUS_WR && (BUS_ADDR == `SCSR_REG_CHAN);
  wire wr_term = BUS_WR && (BUS_ADDR == `SCSR_REG_TERM);
  wire wr_tmo = BUS_WR && (BUS_ADDR == `SCSR_REG_TMO);
  wire wr_read = BUS_WR && (BUS_ADDR == `SCSR_REG_READ);
  wire wr_cancel = BUS_WR && (BUS_ADDR == `SCSR_REG_CANCEL);
  wire wr_rcvar = BUS_WR && (BUS_ADDR == `SCSR_REG_RCVAR);
  wire wr_tmo_ind = BUS_WR && (BUS_ADDR == `SCSR_REG_TMO_IND);
  // channel commands only act when the number names this channel
  wire chan_hit = (BUS_WDATA[`SCSR_CHAN_NUM_LSB+3:`SCSR_CHAN_NUM_LSB] == OWN_CHAN);
  wire open_cmd = wr_chan && chan_hit && BUS_WDATA[`SCSR_CHAN_OPEN_BIT];
  wire close_cmd = wr_chan && chan_hit && BUS_WDATA[`SCSR_CHAN_CLOSE_BIT];
  wire [9:0] read_col = BUS_WDATA[9:0];
  wire read_global = BUS_WDATA[`SCSR_READ_GLOBAL_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // timeout value clamped to the allowed range
  // out-of-range values are held at the top rather than wrapped, so a
  // large setting never turns into a short one
  wire [13:0] tmo_from_bus;
  wire [13:0] tmo_from_var;
  assign tmo_from_bus = (BUS_WDATA > {2'h0, `SCSR_TMO_MAX}) ? `SCSR_TMO_MAX
                        : BUS_WDATA[13:0];
  assign tmo_from_var = (VAR_RDATA > {2'h0, `SCSR_TMO_MAX}) ? `SCSR_TMO_MAX
                        : VAR_RDATA[13:0];

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  wire tick; // 10 ms pulse
  wire err_hit; // a receive fault this cycle
  wire [4:0] err_code; // its result code
  // faults and bytes count only while reception is on
  // a byte with reception off is lost; there is no buffer to keep it
  wire err_live = err_hit && RX_ENABLE;
  wire byte_live = RX_VALID && RX_ENABLE;

  // free-running tick: a read may start mid-period, so its first tick can
  // come early and a timeout of n ends between n-1 and n periods
  scsr_tick #(
    .CNT_W(20),
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .clk(SYS_CLK),
    .rst_n(rst_n),
    .tick(tick)
  );

  // fault flags of the selected port folded into one result code
  scsr_errcode u_err (
    .exp_port(EXP_PORT != 0),
    .err_onchip(RX_ERR_ONCHIP),
    .err_exp(RX_ERR_EXP),
    .hit(err_hit),
    .code(err_code)
  );

  ////////////////////////////////////////////////////////////////////////////
  // settings written by software
  // these hold their values across reads and across channel open or close
  always @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      term <= `SCSR_RST_TERM;
      tmo <= `SCSR_RST_TMO;
      rc_var <= `SCSR_RST_RCVAR;
    end else begin
      if (wr_term) begin
        term <= BUS_WDATA[7:0];
      end
      // only the read timer exists, upper operand bits count toward the clamp
      // a direct write in the load cycle wins: it is the newer setting
      if (wr_tmo) begin
        tmo <= tmo_from_bus;
      end else if (state == ST_LOAD) begin
        tmo <= tmo_from_var;
      end
      if (wr_rcvar) begin
        rc_var <= BUS_WDATA[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read sequencer, channel state and all strobes to the stores
  // one process owns every output it drives, so no output has two writers
  // and every output leaves a flop directly
  always @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      tmo_cnt <= 14'h0000;
      col_ptr <= 10'h000;
      code <= `SCSR_RC_OK;
      CHAN_OPEN <= 1'b0;
      RX_ENABLE <= 1'b0;
      READ_BUSY <= 1'b0;
      READ_DONE <= 1'b0;
      RESULT_CODE <= `SCSR_RC_OK;
      VAR_RD <= 1'b0;
      VAR_WR <= 1'b0;
      VAR_ADDR <= 8'h00;
      VAR_WDATA <= 16'h0000;
      COL_WR <= 1'b0;
      COL_GLOBAL <= 1'b0;
      COL_ADDR <= 10'h000;
      COL_DATA <= 8'h00;
    end else begin
      // strobes last one cycle
      VAR_RD <= 1'b0;
      VAR_WR <= 1'b0;
      COL_WR <= 1'b0;
      READ_DONE <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (wr_read) begin
            READ_BUSY <= 1'b1;
            COL_GLOBAL <= read_global;
            if (read_col == 10'h000) begin
              // dummy read: nothing buffered is kept, receive goes off
              // there is no buffer here, so clearing it costs nothing
              RX_ENABLE <= 1'b0;
              code <= `SCSR_RC_OK;
              state <= ST_REPORT;
            end else if (!CHAN_OPEN) begin
              // a closed channel can never deliver, fail at once
              // report anyway so the program is never left waiting
              code <= (EXP_PORT != 0) ? `SCSR_RC_EX_OTHER : `SCSR_RC_OC_OTHER;
              state <= ST_REPORT;
            end else begin
              col_ptr <= read_col;
              // the count is loaded only at the start of a read
              tmo_cnt <= tmo;
              state <= ST_READ;
            end
          end else if (wr_tmo_ind) begin
            // strobe the store now; its answer is taken two edges later
            // a read written while the fetch runs is not seen: keep them apart
            VAR_ADDR <= BUS_WDATA[7:0];
            VAR_RD <= 1'b1;
            state <= ST_FETCH;
          end else if (PROG_ABORT || TASK_END || err_live) begin
            // no read waiting: the fault still shuts reception
            // and no result is written, since nothing waits for one
            RX_ENABLE <= 1'b0;
          end
        end
        ST_FETCH: begin
          // the strobe is out this cycle; the answer stands in the next one
          state <= ST_LOAD;
        end
        ST_LOAD: begin
          // timeout register takes the variable contents on this edge
          state <= ST_IDLE;
        end
        ST_READ: begin
          if (PROG_ABORT) begin
            // abort outranks all: the program that waits is gone
            code <= `SCSR_RC_ABORT;
            RX_ENABLE <= 1'b0;
            state <= ST_REPORT;
          end else if (TASK_END) begin
            // the task that issued the read has ended: stop receiving
            code <= `SCSR_RC_TASK_END;
            RX_ENABLE <= 1'b0;
            state <= ST_REPORT;
          end else if (err_live) begin
            // every port fault ends the read and shuts reception
            // the byte of a faulty cycle is not stored
            code <= err_code;
            RX_ENABLE <= 1'b0;
            state <= ST_REPORT;
          end else if (wr_cancel) begin
            // reception stays on; later bytes find no read and are dropped
            code <= `SCSR_RC_CANCEL;
            state <= ST_REPORT;
          end else if (byte_live) begin
            // the terminator is stored too, then the read is complete
            COL_WR <= 1'b1;
            COL_ADDR <= col_ptr;
            COL_DATA <= RX_DATA;
            col_ptr <= col_ptr + 10'h001;
            if (RX_DATA == term) begin
              code <= `SCSR_RC_OK;
              state <= ST_REPORT;
            end else if (tick && (tmo_cnt == 14'h0001)) begin
              // last tick together with a plain byte: byte kept, wait ends
              code <= `SCSR_RC_TIMEOUT;
              state <= ST_REPORT;
            end
            // a tick that meets a byte still counts, so timing never stretches
            if (tick && (tmo_cnt != 14'h0000)) begin
              tmo_cnt <= tmo_cnt - 14'h0001;
            end
          end else if (tick && (tmo_cnt != 14'h0000)) begin
            // a zero count never runs down, so the wait is endless
            // the count reaches zero on this tick and the wait ends
            if (tmo_cnt == 14'h0001) begin
              code <= `SCSR_RC_TIMEOUT;
              state <= ST_REPORT;
            end
            tmo_cnt <= tmo_cnt - 14'h0001;
          end
        end
        ST_REPORT: begin
          // codes 13 to 20 have no source here and so never appear
          // one write of the code, then idle: a result is never written twice
          VAR_ADDR <= rc_var;
          VAR_WDATA <= {11'h000, code};
          VAR_WR <= 1'b1;
          RESULT_CODE <= code;
          READ_DONE <= 1'b1;
          READ_BUSY <= 1'b0;
          state <= ST_IDLE;
        end
        default: begin
          // unused codes go home rather than lock up
          state <= ST_IDLE;
        end
      endcase
      // channel commands come last so software has the final word
      // close wins over open when both bits are set in one write
      if (close_cmd) begin
        CHAN_OPEN <= 1'b0;
        RX_ENABLE <= 1'b0;
      end else if (open_cmd) begin
        CHAN_OPEN <= 1'b1;
        RX_ENABLE <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data, valid in the cycle after the strobe only
  // zero outside that cycle, so a stale value is never taken for data
  always @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      BUS_RDATA <= 16'h0000;
    end else if (BUS_RD) begin
      case (BUS_ADDR)
        `SCSR_REG_TERM: BUS_RDATA <= {8'h00, term};
        `SCSR_REG_TMO: BUS_RDATA <= {2'h0, tmo};
        `SCSR_REG_RCVAR: BUS_RDATA <= {8'h00, rc_var};
        `SCSR_REG_STATUS: begin
          BUS_RDATA <= {8'h00, RESULT_CODE, READ_BUSY, RX_ENABLE, CHAN_OPEN};
        end
        default: BUS_RDATA <= 16'h0000; // write-only or unmapped
      endcase
    end else begin
      BUS_RDATA <= 16'h0000;
    end
  end

endmodule
`default_nettype wire

// *** tb/scsr_assertions.sv ***
/* checker for scsr_top: result placement, receive enable and command timing.
   assumes it is bound to scsr_top and sees only its ports. */
`timescale 1ns/1ns
`default_nettype none
module scsr_assertions #(
  parameter [3:0] OWN_CHAN = 4'h0
) (
  input wire logic SYS_CLK,
  input wire logic RSTN,
  input wire logic [7:0] BUS_ADDR,
  input wire logic [15:0] BUS_WDATA,
  input wire logic BUS_WR,
  input wire logic VAR_RD,
  input wire logic VAR_WR,
  input wire logic [7:0] VAR_ADDR,
  input wire logic [15:0] VAR_WDATA,
  input wire logic COL_WR,
  input wire logic [7:0] COL_DATA,
  input wire logic CHAN_OPEN,
  input wire logic RX_ENABLE,
  input wire logic READ_BUSY,
  input wire logic READ_DONE
);
  logic [7:0] term; // terminator as last written
  logic [7:0] rcvar; // result variable as last written
  wire chan_wr = BUS_WR && BUS_ADDR == 8'h00 && BUS_WDATA[7:4] == OWN_CHAN;
  // shadow copies, so a register that never updates shows up below
  always @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      term <= 8'h00;
      rcvar <= 8'h63;
    end else if (BUS_WR && BUS_ADDR == 8'h04) begin
      term <= BUS_WDATA[7:0];
    end else if (BUS_WR && BUS_ADDR == 8'h14) begin
      rcvar <= BUS_WDATA[7:0];
    end
  end
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RSTN);
  a_rc_place: assert property (
    READ_DONE |-> VAR_WR && VAR_ADDR == rcvar && VAR_WDATA[15:5] == 11'h0)
    else $error("result written to wrong place");
  a_no_eth: assert property (
    READ_DONE |-> !(VAR_WDATA[4:0] inside {[5'hD:5'h14]}))
    else $error("reserved result code produced");
  a_open_on: assert property (
    chan_wr && BUS_WDATA[1:0] == 2'h1 |=> CHAN_OPEN && RX_ENABLE)
    else $error("open did not enable channel");
  a_close_off: assert property (
    chan_wr && BUS_WDATA[1] |=> !CHAN_OPEN && !RX_ENABLE)
    else $error("close left channel enabled");
  a_keep_rx: assert property (
    READ_DONE && VAR_WDATA[4:0] == 5'h1 && !BUS_WR |=> $stable(RX_ENABLE))
    else $error("timeout changed receive enable");
  a_err_off: assert property (
    READ_DONE && VAR_WDATA[4:0] > 5'h2 && !BUS_WR |=> !RX_ENABLE)
    else $error("fault left receive enabled");
  a_dummy_ok: assert property (
    BUS_WR && BUS_ADDR == 8'h0C && BUS_WDATA[9:0] == 10'h0 && !READ_BUSY && CHAN_OPEN
    |-> ##2 READ_DONE && VAR_WDATA == 16'h0)
    else $error("dummy read result wrong");
  a_term_end: assert property (
    COL_WR && READ_BUSY && COL_DATA == term |=> READ_DONE && VAR_WDATA == 16'h0)
    else $error("terminator did not end read");
  a_tmo_fetch: assert property (
    BUS_WR && BUS_ADDR == 8'h1C && !READ_BUSY
    |=> VAR_RD && VAR_ADDR == $past(BUS_WDATA[7:0]))
    else $error("timeout variable not fetched");
  c_ok: cover property (READ_DONE && VAR_WDATA == 16'h0);
  c_tmo: cover property (READ_DONE && VAR_WDATA == 16'h1);
  c_cancel: cover property (READ_DONE && VAR_WDATA == 16'h2);
endmodule
bind scsr_top scsr_assertions #(.OWN_CHAN(OWN_CHAN)) scsr_assertions_inst (
  .SYS_CLK, .RSTN, .BUS_ADDR, .BUS_WDATA, .BUS_WR, .VAR_RD, .VAR_WR, .VAR_ADDR,
  .VAR_WDATA, .COL_WR, .COL_DATA, .CHAN_OPEN, .RX_ENABLE, .READ_BUSY, .READ_DONE
);
`default_nettype wire

// *** tb/scsr_peer.sv ***
/* far side model: serial peer sending bytes and the variable store.
   assumes callers hold sends apart by at least one clock. */
`timescale 1ns/1ns
`default_nettype none
module scsr_peer (
  input wire logic clk,
  input wire logic var_rd,
  input wire logic [7:0] var_addr,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic [15:0] var_rdata
);
  logic [15:0] vars [0:255]; // variable store, set by the bench
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'hA5;
    var_rdata = 16'h5A5A;
  end
  // answer a fetch one cycle later; otherwise toggle so stale data never matches
  always @(posedge clk) begin
    var_rdata <= var_rd ? vars[var_addr] : ~var_rdata;
  end
  // one byte, then the data line shows the inverse, not the old byte
  task send(input logic [7:0] b);
    @(posedge clk);
    rx_valid <= 1'b1;
    rx_data <= b;
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_data <= ~b;
  endtask
endmodule
`default_nettype wire

// *** tb/serial_channel_string_reader_tb.sv ***
/* self-checking bench for scsr_top with the peer model.
   assumes rtl/ on the include path; short tick of 20 cycles. */
`timescale 1ns/1ns
`default_nettype none
module serial_channel_string_reader_tb;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0, rd = 1'b0, rd_d = 1'b0, abrt = 1'b0, tend = 1'b0;
  logic [2:0] err = 3'h0;
  wire rxv, vr, vw, cw, cg, opn, rxe, busy, done;
  wire [7:0] rxd, va, cd;
  wire [15:0] vrd, rdat, vwd;
  wire [9:0] ca;
  wire [4:0] rc;
  logic [23:0] rq[$], bq[$], cq[$]; // expected results, bus reads, column writes
  logic [4:0] codes [0:4] = '{5'h3, 5'h4, 5'h7, 5'h5, 5'h6};
  integer n_mismatch = 0, cmp_count = 0, seed = 32'h95e84a9a, i, j, k;
  logic [7:0] term, rcv, b;
  logic [9:0] col;
  logic [23:0] e_done; // oldest result note, taken when a result shows
  always #10 clk = ~clk;
  scsr_top #(.TICK_CYCLES(20)) scsr_top_inst (.SYS_CLK(clk), .RSTN(rstn),
    .BUS_ADDR(addr), .BUS_WDATA(wdata), .BUS_WR(wr), .BUS_RD(rd), .BUS_RDATA(rdat),
    .RX_VALID(rxv), .RX_DATA(rxd), .RX_ERR_ONCHIP(err), .RX_ERR_EXP(7'h00),
    .PROG_ABORT(abrt), .TASK_END(tend), .VAR_RD(vr), .VAR_WR(vw), .VAR_ADDR(va),
    .VAR_WDATA(vwd), .VAR_RDATA(vrd), .COL_WR(cw), .COL_GLOBAL(cg), .COL_ADDR(ca),
    .COL_DATA(cd), .CHAN_OPEN(opn), .RX_ENABLE(rxe), .READ_BUSY(busy),
    .READ_DONE(done), .RESULT_CODE(rc));
  scsr_peer scsr_peer_inst (.clk(clk), .var_rd(vr), .var_addr(va), .rx_valid(rxv),
    .rx_data(rxd), .var_rdata(vrd));
  task chk(input logic [23:0] e, input logic [23:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: expected %h got %h", $time, e, g);
    end
  endtask
  // watcher: each output event takes the oldest note of its kind
  always @(posedge clk) begin
    rd_d <= rd;
    if (rd_d) chk(bq.size() ? bq.pop_front() : 24'hx, {8'h0, rdat});
    if (done) begin
      e_done = rq.size() ? rq.pop_front() : 24'hx;
      chk(e_done, {va, vwd});
      chk({19'h0, e_done[4:0]}, {19'h0, rc});
    end
    if (cw) chk(cq.size() ? cq.pop_front() : 24'hx, {5'h0, cg, ca, cd});
  end
  task wr16(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rd16(input logic [7:0] a, input logic [15:0] e);
    bq.push_back({8'h0, e});
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
  endtask
  task go(input logic [15:0] cmd, input logic [4:0] code);
    rq.push_back({rcv, 11'h0, code});
    wr16(8'h0C, cmd);
  endtask
  task ev(input logic [4:0] v);
    @(posedge clk);
    {tend, abrt, err} <= v;
    @(posedge clk);
    {tend, abrt, err} <= 5'h0;
  endtask
  // bounded wait for the read to finish; k holds the cycles spent
  task idle;
    k = 0;
    repeat (2) @(posedge clk);
    while (busy !== 1'b0 && k < 8000) begin
      @(posedge clk);
      k++;
    end
    if (k >= 8000) n_mismatch++;
    repeat (2) @(posedge clk);
  endtask
  task note(input string s);
    $display("test %s done at %0t", s, $time);
  endtask
  task give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    #400000;
    n_mismatch++;
    give_verdict;
  end
  initial begin
    term = 8'($random(seed));
    rcv = 8'h63;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    rd16(8'h14, 16'h0063);
    rd16(8'h08, 16'h0000);
    rd16(8'h20, 16'h0000);
    wr16(8'h04, {8'h0, term});
    rd16(8'h04, {8'h0, term});
    wr16(8'h00, 16'h0001);
    rd16(8'h18, 16'h0003);
    note("reset_open");
    for (i = 0; i < 2; i++) begin
      col = i ? 10'h3F0 : 10'h005;
      go({i[0], 5'h0, col}, 5'h0);
      for (j = 0; j < 4; j++) begin
        b = 8'($random(seed));
        if (j == 3) b = term;
        else if (b == term) b = ~term;
        cq.push_back({5'h0, i[0], col + j[9:0], b});
        scsr_peer_inst.send(b);
      end
      idle;
    end
    note("string_read");
    wr16(8'h14, 16'h0030);
    rcv = 8'h30;
    wr16(8'h08, 16'h0003);
    go(16'h0007, 5'h1);
    idle;
    chk(24'h1, {23'h0, k > 30 && k < 65});
    wr16(8'h08, 16'h2710);
    rd16(8'h08, 16'h26AC);
    wr16(8'h08, 16'h0000);
    go(16'h0009, 5'h2);
    repeat (300) @(posedge clk);
    chk(24'h1, {23'h0, busy});
    wr16(8'h10, 16'h0000);
    idle;
    note("timeout");
    scsr_peer_inst.vars[7] = 16'h0123;
    wr16(8'h1C, 16'h0007);
    repeat (2) @(posedge clk);
    rd16(8'h08, 16'h0123);
    for (i = 0; i < 5; i++) begin
      wr16(8'h00, 16'h0001);
      go(16'h0001, codes[i]);
      ev(5'h1 << i);
      idle;
    end
    note("faults");
    wr16(8'h00, 16'h0001);
    go(16'h0000, 5'h0);
    idle;
    rd16(8'h18, 16'h0001);
    wr16(8'h00, 16'h0002);
    rd16(8'h18, 16'h0000);
    scsr_peer_inst.send(term);
    go(16'h0004, 5'h7);
    idle;
    rd16(8'h18, 16'h0038);
    note("dummy_close");
    repeat (4) @(posedge clk);
    chk(24'h0, 24'(rq.size() + bq.size() + cq.size()));
    give_verdict;
  end
endmodule
`default_nettype wire
